// file: hdl/flag_branch_bit_shift_unit.sv
// Flag, branch, bit and shift execution unit of an 8-bit core.
// Assumes an APB master issues instructions by writing a command word;
// operands and results live in the unit's own registers.
//
// Our own choices: the APB register port and the placing of the registers.

// Summary of operation
// - Branch on half-carry set or clear
// - Branch on transfer flag set or clear
// - Branch on overflow set or clear
// - Branch on interrupt enable one or zero
// - Set or clear one I/O bit, two cycles
// - Left shift or rotate, old bit 7 to carry
// - Right shift, rotate or arithmetic, updates flags
// - Copy register bit into transfer flag
// - Write transfer flag into register bit
// - Set or clear C, N, Z, V, I singly
// - Set or clear the signed test flag
module flag_branch_bit_shift_unit
  import flag_unit_pkg::*;
(
  input  wire logic        pclk,    // Core clock
  input  wire logic        presetn, // Async reset, active low
  input  wire logic        psel,    // APB select
  input  wire logic        penable, // APB access phase
  input  wire logic        pwrite,  // APB write direction
  input  wire logic [7:0]  paddr,   // APB byte address
  input  wire logic [31:0] pwdata,  // APB write data
  output logic      [31:0] prdata,  // APB read data
  output logic             pready,  // APB ready
  output logic             pslverr, // APB error, unmapped address
  output logic             busy     // Instruction still in progress
);

  // Whole unit state and its next value
  state_t s_q;
  state_t s_d;

  // Decoded command fields from the write data
  op_t            cmd_op;    // Requested opcode
  logic [2:0]     cmd_bit;   // Bit or flag number
  logic [K_W-1:0] cmd_k;     // Signed branch offset
  shift_res_t     sh;        // Shifter answer

  // Bus phase qualifiers
  logic setup_ph;  // First cycle of a transfer
  logic access_ph; // Completing cycle of a transfer
  logic mapped;    // Address hits a register
  logic do_write;  // Write takes effect this edge
  logic issue;     // Command accepted this edge

  // Branch evaluation
  logic            is_branch;  // Opcode is a branch
  logic [2:0]      br_flag;    // Flag tested by the branch
  logic            br_want;    // Value that makes it taken
  logic            br_taken;   // Condition met
  logic [PC_W-1:0] pc_next1;   // Fall-through address
  logic [PC_W-1:0] pc_target;  // Branch target

  // Command field extraction
  always_comb begin
    cmd_op  = op_t'(pwdata[CMD_OP_LSB +: 5]);
    cmd_bit = pwdata[CMD_BIT_LSB +: 3];
    cmd_k   = pwdata[CMD_K_LSB +: K_W];
  end

  // Shifter works on the held working register; its answer is only
  // used when a shift is issued, so other opcodes may pass anything
  shift_unit u_shift (
    .op    (cmd_op),
    .value (s_q.work),
    .carry (s_q.flags[FL_C]),
    .res   (sh)
  );

  // Address decode; zero wait states, so ready is always high
  always_comb begin
    setup_ph  = psel & ~penable;
    access_ph = psel & penable;
    if (paddr == OFS_COMMAND) begin
      mapped = 1'b1;
    end else if (paddr == OFS_WORK) begin
      mapped = 1'b1;
    end else if (paddr == OFS_PC) begin
      mapped = 1'b1;
    end else if (paddr == OFS_IO) begin
      mapped = 1'b1;
    end else if (paddr == OFS_FLAGS) begin
      mapped = 1'b1;
    end else if (paddr == OFS_INFO) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
    do_write = access_ph & pwrite & mapped;
    // A command while busy is dropped; the master must poll busy
    // No error is flagged for it: INFO keeps the record of the
    // instruction that did run, which is what software asks about
    issue    = do_write & (paddr == OFS_COMMAND) & (s_q.busy == 2'h0);
  end

  // Branch decode: which flag and which level make it taken
  // Decoded straight from the bus word, so the outcome is ready at
  // the same edge at which the command write completes
  always_comb begin
    is_branch = 1'b1;
    br_flag   = 3'(FL_H);
    br_want   = 1'b1;
    case (cmd_op)
      branch_half_carry_set: begin
        br_flag = 3'(FL_H);
        br_want = 1'b1;
      end
      branch_half_carry_clear: begin
        br_flag = 3'(FL_H);
        br_want = 1'b0;
      end
      branch_transfer_bit_set: begin
        br_flag = 3'(FL_T);
        br_want = 1'b1;
      end
      branch_transfer_bit_clear: begin
        br_flag = 3'(FL_T);
        br_want = 1'b0;
      end
      branch_overflow_set: begin
        br_flag = 3'(FL_V);
        br_want = 1'b1;
      end
      branch_overflow_clear: begin
        br_flag = 3'(FL_V);
        br_want = 1'b0;
      end
      branch_irq_enabled: begin
        br_flag = 3'(FL_I);
        br_want = 1'b1;
      end
      branch_irq_disabled: begin
        br_flag = 3'(FL_I);
        br_want = 1'b0;
      end
      default: begin
        is_branch = 1'b0;    // Not a branch
      end
    endcase
    // Flag picked by number from the status byte
    br_taken  = is_branch & (s_q.flags[br_flag] == br_want);
    pc_next1  = s_q.pc + PC_W'(1);
    // The offset is sign-extended first; a target beyond either end
    // wraps through the 16-bit counter
    // Target is PC plus signed offset plus one
    pc_target = pc_next1 + PC_W'($signed(cmd_k));
  end

  // Next-state logic: bus writes, instruction effects, read capture
  always_comb begin
    s_d = s_q;

    // Busy counts down the cycles of the running instruction
    // Two bits are enough: no instruction here lasts above two cycles
    if (s_q.busy != 2'h0) begin
      s_d.busy = s_q.busy - 2'h1;
    end

    // Plain register writes from software
    if (do_write) begin
      if (paddr == OFS_WORK) begin
        s_d.work = pwdata[7:0];
      end else if (paddr == OFS_PC) begin
        s_d.pc = pwdata[PC_W-1:0];
      end else if (paddr == OFS_IO) begin
        s_d.io = pwdata[7:0];
      end else if (paddr == OFS_FLAGS) begin
        s_d.flags = pwdata[7:0];
      end
    end

    // A plain write and an issue never share a cycle, so the order of
    // the two blocks cannot lose an update
    // Instruction execution; every instruction is one program word
    if (issue) begin
      s_d.pc    = pc_next1;
      s_d.taken = 1'b0;
      s_d.bad   = 1'b0;
      s_d.cyc   = CYC_ONE;
      if (is_branch) begin
        // Flags left alone by every branch
        if (br_taken) begin
          s_d.pc    = pc_target;
          s_d.taken = 1'b1;
          s_d.cyc   = CYC_TWO;    // Taken costs two
        end else begin
          s_d.cyc   = CYC_ONE;    // Untaken costs one
        end
      end else begin
        case (cmd_op)
          io_bit_set: begin
            s_d.io[cmd_bit] = 1'b1;  // Other bits kept
            s_d.cyc         = CYC_TWO;
          end
          io_bit_clear: begin
            s_d.io[cmd_bit] = 1'b0;
            s_d.cyc         = CYC_TWO;
          end
          shift_left_logical,
          rotate_left_carry,
          shift_right_logical,
          rotate_right_carry,
          shift_right_arith: begin
            // Z, C, N, V from the shifter; other flags kept
            s_d.work        = sh.value;
            s_d.flags[FL_C] = sh.c;
            s_d.flags[FL_Z] = sh.z;
            s_d.flags[FL_N] = sh.n;
            s_d.flags[FL_V] = sh.v;
          end
          bit_to_transfer_flag: begin
            s_d.flags[FL_T] = s_q.work[cmd_bit];
          end
          transfer_flag_to_bit: begin
            s_d.work[cmd_bit] = s_q.flags[FL_T];
          end
          flag_set: begin
            s_d.flags[cmd_bit] = 1'b1;  // Own flag only
          end
          flag_clear: begin
            s_d.flags[cmd_bit] = 1'b0;
          end
          overflow_flag_on: begin
            s_d.flags[FL_V] = 1'b1;
          end
          signed_flag_on: begin
            s_d.flags[FL_S] = 1'b1;
          end
          signed_flag_off: begin
            s_d.flags[FL_S] = 1'b0;
          end
          op_nop: begin
            s_d.cyc = CYC_ONE;          // Only the PC moves
          end
          default: begin
            // Unknown opcode: no effect beyond marking it
            // PC stays put so software can see where the bad word sat
            s_d.pc  = s_q.pc;
            s_d.bad = 1'b1;
          end
        endcase
      end
      s_d.busy = s_d.cyc;
    end

    // Read data captured in setup so it is stable in access
    // Trade-off: a flop on prdata keeps the read path short, at the
    // price of showing state as it stood in the setup cycle
    if (setup_ph) begin
      if (paddr == OFS_WORK) begin
        s_d.rdata = {24'h000000, s_q.work};
      end else if (paddr == OFS_PC) begin
        s_d.rdata = {{(32-PC_W){1'b0}}, s_q.pc};
      end else if (paddr == OFS_IO) begin
        s_d.rdata = {24'h000000, s_q.io};
      end else if (paddr == OFS_FLAGS) begin
        s_d.rdata = {24'h000000, s_q.flags};
      end else if (paddr == OFS_INFO) begin
        s_d.rdata = '0;
        s_d.rdata[INFO_BUSY]        = (s_q.busy != 2'h0);
        s_d.rdata[INFO_TAKEN]       = s_q.taken;
        s_d.rdata[INFO_BAD]         = s_q.bad;
        s_d.rdata[INFO_CYC +: 2]    = s_q.cyc;
      end else begin
        // Command word and holes read as zero
        s_d.rdata = 32'h00000000;
      end
    end
  end

  // State register
  // Reset leaves rdata at zero, so a read straight after release
  // sees zero whatever was last captured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.flags <= FLAGS_RST;
      s_q.work  <= WORK_RST;
      s_q.pc    <= PC_RST;
      s_q.io    <= IO_RST;
      s_q.busy  <= 2'h0;
      s_q.taken <= 1'b0;
      s_q.bad   <= 1'b0;
      s_q.cyc   <= 2'h0;
      s_q.rdata <= 32'h00000000;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs; pready never stalls, every access finishes in one cycle
  // pslverr is decoded from the live address, so it needs no flop
  always_comb begin
    prdata  = s_q.rdata;
    pready  = 1'b1;
    pslverr = access_ph & ~mapped;
    busy    = (s_q.busy != 2'h0);
  end

endmodule

// file: common/flag_unit_pkg.sv
// Package for the flag, branch, bit and shift execution unit.
// Assumes a single core clock and an APB register port on the unit.
package flag_unit_pkg;

  // Register byte offsets on the APB port
  localparam logic [7:0] OFS_COMMAND = 8'h00; // Instruction issue
  localparam logic [7:0] OFS_WORK    = 8'h04; // Working register
  localparam logic [7:0] OFS_PC      = 8'h08; // Program counter
  localparam logic [7:0] OFS_IO      = 8'h0C; // Addressed I/O register
  localparam logic [7:0] OFS_FLAGS   = 8'h10; // status_flags_register
  localparam logic [7:0] OFS_INFO    = 8'h14; // Execution state, read only

  // Command word field positions
  localparam int CMD_OP_LSB  = 0;  // Opcode, 5 bits
  localparam int CMD_BIT_LSB = 8;  // Bit or flag number, 3 bits
  localparam int CMD_K_LSB   = 16; // Signed branch offset, 7 bits

  // Info word field positions
  localparam int INFO_BUSY  = 0;
  localparam int INFO_TAKEN = 1;
  localparam int INFO_BAD   = 2;
  localparam int INFO_CYC   = 4; // Two bits: cycles of last instruction

  // Flag positions in the status byte
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam int FL_T = 6;
  localparam int FL_I = 7;

  // Widths and reset values
  localparam int PC_W = 16;
  localparam int K_W  = 7;
  localparam logic [7:0]      FLAGS_RST = 8'h00;
  localparam logic [7:0]      WORK_RST  = 8'h00;
  localparam logic [7:0]      IO_RST    = 8'h00;
  localparam logic [PC_W-1:0] PC_RST    = 16'h0000;

  // Cycle counts per instruction class
  localparam logic [1:0] CYC_ONE   = 2'h1; // Single cycle / not taken
  localparam logic [1:0] CYC_TWO   = 2'h2; // Taken branch, I/O bit

  // Opcodes accepted in the command word
  typedef enum logic [4:0] {
    op_nop,
    branch_half_carry_set,
    branch_half_carry_clear,
    branch_transfer_bit_set,
    branch_transfer_bit_clear,
    branch_overflow_set,
    branch_overflow_clear,
    branch_irq_enabled,
    branch_irq_disabled,
    io_bit_set,
    io_bit_clear,
    shift_left_logical,
    shift_right_logical,
    rotate_left_carry,
    rotate_right_carry,
    shift_right_arith,
    bit_to_transfer_flag,
    transfer_flag_to_bit,
    flag_set,
    flag_clear,
    overflow_flag_on,
    signed_flag_on,
    signed_flag_off
  } op_t;

  // Shifter answer
  typedef struct packed {
    logic [7:0] value;
    logic       c;
    logic       z;
    logic       n;
    logic       v;
  } shift_res_t;

  // Whole state of the unit
  typedef struct packed {
    logic [7:0]      flags;
    logic [7:0]      work;
    logic [PC_W-1:0] pc;
    logic [7:0]      io;
    logic [1:0]      busy;
    logic            taken;
    logic            bad;
    logic [1:0]      cyc;
    logic [31:0]     rdata;
  } state_t;

endpackage

// file: hdl/shift_unit.sv
// Combinational one-bit shifter with the flag results of a shift.
// Assumes the caller only looks at the answer for the shift opcodes.
module shift_unit
  import flag_unit_pkg::*;
(
  input  wire op_t        op,    // Opcode being executed
  input  wire logic [7:0] value, // Working register before the shift
  input  wire logic       carry, // Carry flag before the shift
  output shift_res_t      res    // Shifted value and new flags
);

  // Shift datapath and flags
  always_comb begin
    res = '0;
    case (op)
      shift_left_logical: begin
        res.value = {value[6:0], 1'b0};
        res.c     = value[7];
      end
      rotate_left_carry: begin
        res.value = {value[6:0], carry};
        res.c     = value[7];
      end
      shift_right_logical: begin
        res.value = {1'b0, value[7:1]};
        res.c     = value[0];
      end
      rotate_right_carry: begin
        res.value = {carry, value[7:1]};
        res.c     = value[0];
      end
      shift_right_arith: begin
        res.value = {value[7], value[7:1]};  // Sign kept
        res.c     = value[0];
      end
      default: begin
        res.value = value;                   // Not a shift
        res.c     = carry;
      end
    endcase
    // Result flags; overflow is N xor C after the shift
    res.z = (res.value == 8'h00);
    res.n = res.value[7];
    res.v = res.value[7] ^ res.c;
  end

endmodule

// file: bench/flag_unit_sva.sv
// Checker: instruction lengths on busy, status byte reads.
// Assumes binding to the unit's top module ports.
module flag_unit_sva
  import flag_unit_pkg::*;
(
  input wire logic        pclk,    // Core clock
  input wire logic        presetn, // Async reset, active low
  input wire logic        psel,    // APB select
  input wire logic        penable, // APB access phase
  input wire logic        pwrite,  // APB write
  input wire logic [7:0]  paddr,   // APB address
  input wire logic [31:0] pwdata,  // APB write data
  input wire logic [31:0] prdata,  // APB read data
  input wire logic        pready,  // APB ready
  input wire logic        busy     // Instruction running
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic go;  // Command taken at this edge
  op_t  opc; // Opcode on the bus
  // Busy commands are dropped, so only idle ones count
  assign go  = psel & penable & pwrite & pready & !busy
             & (paddr == OFS_COMMAND);
  assign opc = op_t'(pwdata[4:0]);
  // Branches last one or two cycles
  AST_HC_LEN: assert property (go && opc inside
    {branch_half_carry_set, branch_half_carry_clear}
    |=> busy ##2 !busy) else $error("h branch");
  AST_T_LEN: assert property (go && opc inside
    {branch_transfer_bit_set, branch_transfer_bit_clear}
    |=> busy ##2 !busy) else $error("t branch");
  AST_V_LEN: assert property (go && opc inside
    {branch_overflow_set, branch_overflow_clear}
    |=> busy ##2 !busy) else $error("v branch");
  AST_I_LEN: assert property (go && opc inside
    {branch_irq_enabled, branch_irq_disabled}
    |=> busy ##2 !busy) else $error("i branch");
  AST_IO_LEN: assert property (go && opc inside
    {io_bit_set, io_bit_clear}
    |=> $rose(busy) ##1 $stable(busy) ##1 $fell(busy))
    else $error("io len");
  AST_SHL_LEN: assert property (go && opc inside
    {shift_left_logical, rotate_left_carry}
    |=> busy ##1 !busy) else $error("left len");
  AST_SHR_LEN: assert property (go && opc inside
    {shift_right_logical, rotate_right_carry, shift_right_arith}
    |=> busy ##1 !busy) else $error("right len");
  AST_BIT_LEN: assert property (go && opc inside
    {bit_to_transfer_flag, transfer_flag_to_bit}
    |=> $rose(busy) ##1 $fell(busy)) else $error("bit len");
  AST_FLAG_LEN: assert property (go && opc inside
    {flag_set, flag_clear, overflow_flag_on}
    |=> busy ##1 !busy) else $error("flag len");
  AST_SGN_LEN: assert property (go && opc inside
    {signed_flag_on, signed_flag_off}
    |=> busy ##1 !busy) else $error("signed len");
  AST_FLAGS_RD: assert property (psel && penable && !pwrite &&
    paddr == OFS_FLAGS |-> prdata[31:8] == 24'h000000) else $error("flags rd");
  // Main scenarios reached
  cover property (go && opc == io_bit_set);
  cover property (go && opc == rotate_right_carry);
  cover property (go && opc == branch_irq_enabled ##1 busy [*2]);
endmodule
bind flag_branch_bit_shift_unit flag_unit_sva i_flag_unit_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .busy(busy));

// file: bench/flag_branch_bit_shift_unit_tb_top.sv
// Bench: issues instructions by APB and reads results back.
// Assumes zero or more wait states and the busy output.
module flag_branch_bit_shift_unit_tb_top import flag_unit_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite; // Bus control
  logic [7:0]  paddr;                     // Byte address
  logic [31:0] pwdata, prdata;            // Data both ways
  logic        pready, pslverr, busy;     // Answers
  int          errors, num_checks;        // Tallies
  logic [31:0] q;                         // Last read data
  logic        e;                         // Last error bit
  logic [6:0]  k;                         // Branch offset
  logic        tk;                        // Branch expected taken
  logic [31:0] fw, pcx, infx;             // Branch flags, PC and INFO
  logic [7:0]  fb;                        // Single flag mask
  int          fl [8] = '{FL_H, FL_H, FL_T, FL_T, FL_V, FL_V, FL_I, FL_I};
  op_t         sop [6] = '{shift_left_logical, shift_right_logical,
    rotate_left_carry, rotate_right_carry, shift_right_arith,
    shift_left_logical};
  logic [7:0]  sw [6] = '{8'h81, 8'h81, 8'h81, 8'h81, 8'h81, 8'h80};
  logic [7:0]  sf [6] = '{8'hF1, 8'hF1, 8'hF1, 8'hF1, 8'hF1, 8'h00};
  logic [7:0]  xw [6] = '{8'h02, 8'h40, 8'h03, 8'hC0, 8'hC0, 8'h00};
  logic [7:0]  xf [6] = '{8'hF9, 8'hF9, 8'hF9, 8'hF5, 8'hF5, 8'h0B};
  flag_branch_bit_shift_unit i_flag_branch_bit_shift_unit (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy));
  // 25 ns clock
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;
  // Verdict and end of run
  task automatic end_sim;
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Word compare
  task automatic chk(input string nm, input logic [31:0] x, y);
    num_checks++;
    if (y !== x) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, x, y);
    end
  endtask
  // One transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read and compare
  task automatic rchk(input logic [7:0] a, input logic [31:0] x,
                      input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, x, q);
  endtask
  // Issue a command, then wait for the unit to go idle
  task automatic run(input op_t op, input logic [2:0] b,
                     input logic [6:0] ko);
    apb(1'b1, OFS_COMMAND, {9'h000, ko, 5'h00, b, 3'h0, op});
    do begin
      @(posedge pclk);
    end while (busy !== 1'b0);
  endtask
  // Load operands, run, compare status byte and working register
  task automatic opchk(input op_t op, input logic [2:0] b,
                       input logic [7:0] fi, wi, fx, wx);
    apb(1'b1, OFS_FLAGS, {24'h0, fi});
    apb(1'b1, OFS_WORK, {24'h0, wi});
    run(op, b, 7'h00);
    rchk(OFS_FLAGS, {24'h0, fx}, "flags");
    rchk(OFS_WORK, {24'h0, wx}, "work");
  endtask
  // Watchdog; the tests take about 900 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFS_FLAGS, 32'h0, "flags_rst");
    // Each branch with its flag both ways, the other flags opposite
    for (int i = 0; i < 16; i++) begin
      k = i[1] ? 7'h40 : 7'h3F;
      // Flag level is i[0], clear variant when i[1]; taken if they differ
      tk = (i[0] != i[1]);
      fw = i[0] ? 32'h1 << fl[i/2] : ~(32'h1 << fl[i/2]) & 32'hFF;
      pcx = tk ? 32'(16'(16'h0101 + {{9{k[6]}}, k})) : 32'h0101;
      infx = tk ? 32'h22 : 32'h10;
      apb(1'b1, OFS_FLAGS, fw);
      apb(1'b1, OFS_PC, 32'h0100);
      run(op_t'(i / 2 + 1), 3'h0, k);
      rchk(OFS_PC, pcx, "pc");
      rchk(OFS_INFO, infx, "info");
      rchk(OFS_FLAGS, fw, "br_flags");
    end
    // I/O bit set and clear, status byte untouched
    apb(1'b1, OFS_IO, 32'h5A);
    apb(1'b1, OFS_FLAGS, 32'hA5);
    run(io_bit_set, 3'h0, 7'h00);
    rchk(OFS_IO, 32'h5B, "io_set");
    rchk(OFS_INFO, 32'h20, "io_cyc");
    run(io_bit_clear, 3'h6, 7'h00);
    rchk(OFS_IO, 32'h1B, "io_clr");
    rchk(OFS_FLAGS, 32'hA5, "io_flags");
    // Shifts, rotates and a zero result
    for (int i = 0; i < 6; i++) begin
      opchk(sop[i], 3'h0, sf[i], sw[i], xf[i], xw[i]);
    end
    // Bit moves through the transfer flag
    opchk(bit_to_transfer_flag, 3'h4, 8'hBF, 8'h10, 8'hFF, 8'h10);
    opchk(bit_to_transfer_flag, 3'h3, 8'h40, 8'hF7, 8'h00, 8'hF7);
    opchk(transfer_flag_to_bit, 3'h7, 8'h40, 8'h00, 8'h40, 8'h80);
    opchk(transfer_flag_to_bit, 3'h0, 8'hBF, 8'hFF, 8'hBF, 8'hFE);
    // Every flag number set and cleared alone
    for (int f = 0; f < 8; f++) begin
      fb = 8'h01 << f;
      opchk(flag_set, 3'(f), 8'h00, 8'h5A, fb, 8'h5A);
      opchk(flag_clear, 3'(f), 8'hFF, 8'h5A, ~fb, 8'h5A);
    end
    opchk(overflow_flag_on, 3'h0, 8'h00, 8'h00, 8'h08, 8'h00);
    opchk(signed_flag_on, 3'h0, 8'h00, 8'h00, 8'h10, 8'h00);
    opchk(signed_flag_off, 3'h0, 8'hFF, 8'h00, 8'hEF, 8'h00);
    // Unmapped address answers with an error and zero
    apb(1'b0, 8'h18, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    chk("rd_unmapped", 32'h0, q);
    // Nop moves only the PC; an unknown opcode is marked, PC held
    apb(1'b1, OFS_PC, 32'h0200);
    run(op_nop, 3'h0, 7'h00);
    rchk(OFS_PC, 32'h0201, "pc_nop");
    run(op_t'(5'h17), 3'h0, 7'h00);
    rchk(OFS_PC, 32'h0201, "pc_bad");
    rchk(OFS_INFO, 32'h14, "info_bad");
    // Second reset in mid-run returns every register to zero
    apb(1'b1, OFS_FLAGS, 32'hFF);
    apb(1'b1, OFS_IO, 32'hC3);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFS_FLAGS, 32'h0, "flags_rst2");
    rchk(OFS_PC, 32'h0, "pc_rst2");
    rchk(OFS_IO, 32'h0, "io_rst2");
    rchk(OFS_INFO, 32'h0, "info_rst2");
    end_sim();
  end
endmodule
